/* include/sbc_event_pkg.sv */
package sbc_event_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int REL_TIME_US = 10;
    localparam int REL_CYC = (REL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LIN_DOM_TIME_US = 20000;
    localparam int LIN_DOM_CYC_DEF = (LIN_DOM_TIME_US * 1000) / CLK_PERIOD_NS;
    localparam int EVT_DELAY_US = 20;
    localparam int EVT_DELAY_CYC = (EVT_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 32;
    localparam int A_CAN_WAKE = 0;
    localparam int A_LOC_RISE = 1;
    localparam int A_LOC_FALL = 2;
    localparam int A_LIN_WAKE = 3;
    localparam int A_SUP_REC = 4;
    localparam int A_LIN_TW = 5;
    localparam int A_CAN_TW = 6;
    localparam int A_MAIN_TW = 7;
    localparam int A_SENS_TW = 8;
    localparam int A_LIN_TSD = 9;
    localparam int A_CAN_TSD = 10;
    localparam int A_MAIN_TSD = 11;
    localparam int A_SENS_TSD = 12;
    localparam int A_BUS_SIL = 13;
    localparam int A_CAN_TXD_TO = 14;
    localparam int A_RXD_CLAMP = 15;
    localparam int A_BUS_DOM = 16;
    localparam int A_BUS_CLAMP = 17;
    localparam int A_OSC_FAULT = 18;
    localparam int A_BAT_UV = 19;
    localparam int A_LOGIC_UV = 20;
    localparam int A_LOGIC_OV = 21;
    localparam int A_IO_UV = 22;
    localparam int A_N = 23;
    localparam int F_POWER_ON = 5;
    localparam int F_SPI_FAIL = 14;
    localparam int F_FD_OVF = 15;
    localparam int F_TRX_FAIL = 17;
    localparam int F_LIN_TXD_TO = 25;
    localparam int F_N = 26;
    localparam logic [F_N-1:0] EN_ALWAYS = 26'h000BC20;
    localparam logic [F_N-1:0] FLAG_RESET = 26'h0000000;
    localparam logic [2:0] DEV_SLEEP = 3'h1;
    localparam logic [2:0] DEV_NORMAL = 3'h7;
    localparam logic [1:0] CAN_NORMAL = 2'h1;
    localparam logic [1:0] CAN_SILENT = 2'h3;
    localparam logic [5:0] SPI_LEN_A = 6'h10;
    localparam logic [5:0] SPI_LEN_B = 6'h18;
    localparam logic [5:0] SPI_LEN_C = 6'h20;
    typedef enum logic [1:0] {
        G_OFF = 2'b00,
        G_RUN = 2'b01,
        G_BLOCK = 2'b10
    } guard_state_t;
endpackage

/* include/lin_guard_if.sv */
interface lin_guard_if;
    logic txd;
    logic normal;
    logic drv_en;
    logic timeout;
    modport guard (input txd, input normal, output drv_en, output timeout);
    modport user (output txd, output normal, input drv_en, input timeout);
endinterface

/* logic/lin_txd_guard.sv */
module lin_txd_guard #(
    parameter int unsigned TO_CYC = 32'd1
) (
    input wire logic clk,
    input wire logic rst,
    lin_guard_if.guard g
);
    import sbc_event_pkg::*;

    guard_state_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [CNT_W-1:0] hi_q, hi_d;
    logic to_q, to_d;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        to_d = 1'b0;
        hi_d = g.txd ? hi_q + 1'b1 : '0;
        if (!g.normal) begin
            state_d = G_OFF;
            cnt_d = '0;
        end else begin
            unique case (state_q)
                G_OFF: begin
                    // A low input at mode entry must first prove itself released.
                    state_d = g.txd ? G_RUN : G_BLOCK;
                    cnt_d = '0;
                end
                G_RUN: begin
                    if (g.txd) begin
                        cnt_d = '0;
                    end else if (cnt_q >= TO_CYC) begin
                        state_d = G_BLOCK;
                        cnt_d = '0;
                        to_d = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                G_BLOCK: begin
                    if (!g.txd) begin
                        cnt_d = '0;
                    end else if (cnt_q >= CNT_W'(REL_CYC)) begin
                        state_d = G_RUN;
                        cnt_d = '0;
                    end else begin
                        cnt_d = cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_d = G_OFF;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= G_OFF;
            cnt_q <= '0;
            hi_q <= '0;
            to_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            hi_q <= hi_d;
            to_q <= to_d;
        end
    end

    assign g.drv_en = (state_q == G_RUN);
    assign g.timeout = to_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_TO_OFF: assert property (
        state_q == G_RUN && !g.txd && g.normal && cnt_q >= TO_CYC |=> !g.drv_en && g.timeout)
        else $error("driver stayed on after dominant time-out");
    AST_REL_HIGH: assert property (
        $rose(g.drv_en) && $past(state_q) == G_BLOCK |-> hi_q > CNT_W'(REL_CYC))
        else $error("driver re-enabled before the high period");
    AST_ENTRY_LOW: assert property (
        $rose(g.normal) && !g.txd |=> !g.drv_en ##1 !g.drv_en)
        else $error("driver enabled with low input at mode entry");
    AST_OFF_MODE: assert property (
        !g.normal |=> !g.drv_en && !g.timeout)
        else $error("guard active outside normal mode");
    COV_TIMEOUT: cover property (g.timeout);
endmodule

/* logic/evt_alert_delay.sv */
module evt_alert_delay #(
    parameter int unsigned DELAY_CYC = 32'd1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic clear_any,
    input wire logic pending,
    output logic alert
);
    import sbc_event_pkg::*;

    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic alert_q, alert_d;

    // Batching events behind one delay keeps the host from being hit per event.
    always_comb begin
        cnt_d = cnt_q;
        alert_d = alert_q;
        if (clear_any) begin
            alert_d = 1'b0;
            cnt_d = DELAY_CYC;
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
            if (cnt_q == CNT_W'(1)) begin
                alert_d = pending;
            end
        end else begin
            alert_d = pending;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_q <= '0;
            alert_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            alert_q <= alert_d;
        end
    end

    assign alert = alert_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_RELEASE: assert property (clear_any |=> !alert)
        else $error("alert not released on clear");
    AST_EXPIRE: assert property (
        cnt_q == CNT_W'(1) && !clear_any |=> alert == $past(pending))
        else $error("alert wrong at delay expiry");
    COV_REALERT: cover property (clear_any ##1 !alert ##1 cnt_q == CNT_W'(1) && pending);
endmodule

/* logic/wake_event_capture.sv */
// Notes on behaviour
// - LIN input stuck low too long disables driver.
// - Re-enable after input high over 10 us.
// - Second LIN channel has its own guard timer.
// - Low input at Normal entry keeps driver off.
// - Time-out guard runs only in LIN Normal.
// - Second LIN pin outputs fail-safe source in fail-safe.
// - Battery loss tri-states bus and I/O drivers.
// - Wake events set flags, pull receive outputs low.
// - Five wake captures come up disabled.
// - Power-on flag always captured after power-up.
// - Thermal warnings disabled at reset, gated by Normal mode or regulator on.
// - Thermal shutdown flags always captured.
// - Bad serial command length/mode/lock flags failure.
// - Frame detect counter overflow always captured.
// - Bus silence captured when enabled.
// - CAN transceiver failure from three causes.
// - Bus dominant time-out captured outside Sleep.
// - Bus recessive clamp captured outside Sleep.
// - Oscillator fault captured when enabled.
// - Four supply events, disabled at reset.
// - Captured events recorded, signalled on receive pins.
// - Flags clear on written one only.
// - Receive pin alerts only when transceiver inactive.
// - Enabled event in Sleep requests wake-up.
// - Clear releases pins, re-alert after delay.
module wake_event_capture #(
    parameter int unsigned LIN_DOM_CYC = sbc_event_pkg::LIN_DOM_CYC_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [sbc_event_pkg::A_N-1:0] analog_evt,
    input wire logic battery_supply_ok,
    input wire logic logic_supply_ok,
    input wire logic can_rx_bit,
    input wire logic lin_rx_bit,
    input wire logic [1:0] lin_transmit_input,
    output logic second_lin_transmit_out,
    output logic second_lin_transmit_oe_n,
    input wire logic [2:0] device_mode_field,
    input wire logic [1:0] can_mode_field,
    input wire logic [1:0] lin_mode_normal,
    input wire logic lin_fail_safe,
    input wire logic fail_source_bit,
    input wire logic main_ldo_on,
    input wire logic sensor_ldo_on,
    input wire logic spi_cmd_done,
    input wire logic [5:0] spi_clk_count,
    input wire logic spi_mode_illegal,
    input wire logic spi_locked_write,
    input wire logic fd_err_overflow,
    input wire logic enable_write,
    input wire logic [sbc_event_pkg::F_N-1:0] enable_wdata,
    input wire logic [sbc_event_pkg::F_N-1:0] flag_clear,
    output logic [sbc_event_pkg::F_N-1:0] event_flags,
    output logic [sbc_event_pkg::F_N-1:0] capture_enable,
    output logic [1:0] lin_tx_enable,
    output logic rxd_can_o,
    output logic rxd_can_oe_n,
    output logic rxd_lin_o,
    output logic rxd_lin_oe_n,
    output logic can_bus_oe_n,
    output logic [1:0] lin_bus_oe_n,
    output logic wake_request
);
    import sbc_event_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Input synchronisers for everything arriving from the analog side.

    localparam int S_N = A_N + 6;
    // Transmit and receive lines rest high.
    // Clearing them would fake a held-low input.
    localparam logic [S_N-1:0] SYNC_IDLE = {2'b11, 2'b00, 2'b11, {A_N{1'b0}}};

    logic [S_N-1:0] raw;
    logic [S_N-1:0] sync1_q;
    logic [S_N-1:0] sync2_q;

    assign raw = {can_rx_bit, lin_rx_bit, battery_supply_ok,
                  logic_supply_ok, lin_transmit_input, analog_evt};

    always_ff @(posedge clk) begin
        if (rst) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end else begin
            sync1_q <= raw;
            sync2_q <= sync1_q;
        end
    end

    logic [A_N-1:0] a;
    logic [1:0] txd_s;
    logic logic_s;
    logic batt_s;
    logic lin_rx_s;
    logic can_rx_s;

    assign a = sync2_q[A_N-1:0];
    assign txd_s = sync2_q[A_N+1:A_N];
    assign logic_s = sync2_q[A_N+2];
    assign batt_s = sync2_q[A_N+3];
    assign lin_rx_s = sync2_q[A_N+4];
    assign can_rx_s = sync2_q[A_N+5];

    ////////////////////////////////////////////////////////////////////////
    // Mode decode.

    logic sleep;
    logic dev_normal;
    logic can_active;

    assign sleep = (device_mode_field == DEV_SLEEP);
    assign dev_normal = (device_mode_field == DEV_NORMAL);
    assign can_active = (can_mode_field == CAN_NORMAL) || (can_mode_field == CAN_SILENT);

    ////////////////////////////////////////////////////////////////////////
    // LIN transmit guards, one independent timer per channel.

    lin_guard_if gif[2] ();
    logic [1:0] lin_drv_en;
    logic [1:0] lin_to;

    for (genvar i = 0; i < 2; i++) begin : g_lin
        // In fail-safe the second pin is an output, so its guard must not run.
        if (i == 1) begin : g_ch2
            assign gif[i].normal = lin_mode_normal[i] && !lin_fail_safe;
        end else begin : g_ch1
            assign gif[i].normal = lin_mode_normal[i];
        end
        assign gif[i].txd = txd_s[i];
        assign lin_drv_en[i] = gif[i].drv_en;
        assign lin_to[i] = gif[i].timeout;
        lin_txd_guard #(
            .TO_CYC(LIN_DOM_CYC)
        ) u_guard (
            .clk(clk),
            .rst(rst),
            .g(gif[i])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Event sources.

    logic spi_len_ok;
    logic spi_bad;
    logic [F_N-1:0] src;

    assign spi_len_ok = (spi_clk_count == SPI_LEN_A) || (spi_clk_count == SPI_LEN_B)
                        || (spi_clk_count == SPI_LEN_C);
    assign spi_bad = spi_cmd_done && (!spi_len_ok || spi_mode_illegal || spi_locked_write);

    logic por_q, por_d;

    always_comb begin
        src = '0;
        src[4:0] = a[A_SUP_REC:A_CAN_WAKE];
        src[F_POWER_ON] = !por_q;
        src[6] = a[A_LIN_TW] && dev_normal;
        src[7] = a[A_CAN_TW] && dev_normal;
        src[8] = a[A_MAIN_TW] && main_ldo_on;
        src[9] = a[A_SENS_TW] && sensor_ldo_on;
        src[13:10] = a[A_SENS_TSD:A_LIN_TSD];
        src[F_SPI_FAIL] = spi_bad && !sleep;
        src[F_FD_OVF] = fd_err_overflow;
        src[16] = a[A_BUS_SIL];
        src[F_TRX_FAIL] = !sleep && (a[A_CAN_TXD_TO]
            || (a[A_LOGIC_UV] && can_mode_field == CAN_NORMAL)
            || (a[A_RXD_CLAMP] && can_active));
        src[18] = a[A_BUS_DOM] && !sleep;
        src[19] = a[A_BUS_CLAMP] && !sleep;
        src[20] = a[A_OSC_FAULT];
        src[24:21] = a[A_IO_UV:A_BAT_UV];
        src[F_LIN_TXD_TO] = |lin_to;
    end

    ////////////////////////////////////////////////////////////////////////
    // Enables, sticky flags and the wake request.

    logic [F_N-1:0] en_q, en_d;
    logic [F_N-1:0] flags_q, flags_d;
    logic [F_N-1:0] set_v;
    logic wake_q, wake_d;

    always_comb begin
        por_d = 1'b1;
        // Always-captured events cannot be masked by software.
        en_d = enable_write ? (enable_wdata | EN_ALWAYS) : en_q;
        set_v = src & en_q;
        // A set arriving with its clear wins, so no event is lost.
        flags_d = (flags_q & ~flag_clear) | set_v;
        wake_d = sleep && (|set_v);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            por_q <= 1'b0;
            en_q <= EN_ALWAYS;
            flags_q <= FLAG_RESET;
            wake_q <= 1'b0;
        end else begin
            por_q <= por_d;
            en_q <= en_d;
            flags_q <= flags_d;
            wake_q <= wake_d;
        end
    end

    assign event_flags = flags_q;
    assign capture_enable = en_q;
    assign wake_request = wake_q;

    ////////////////////////////////////////////////////////////////////////
    // Receive-pin alert with re-alert delay.

    logic alert;
    logic clear_any;

    assign clear_any = |(flag_clear & flags_q);

    evt_alert_delay #(
        .DELAY_CYC(EVT_DELAY_CYC)
    ) u_alert (
        .clk(clk),
        .rst(rst),
        .clear_any(clear_any),
        .pending(|flags_q),
        .alert(alert)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    logic pull_low;
    logic rxd_can_q, rxd_can_d;
    logic rxd_lin_q, rxd_lin_d;
    logic hiz_q, hiz_d;
    logic [1:0] lin_oe_n_q, lin_oe_n_d;
    logic l2_q, l2_d;
    logic l2_oe_n_q, l2_oe_n_d;

    always_comb begin
        pull_low = alert && batt_s && logic_s;
        // Active transceivers carry the bus stream, so alerts stay off them.
        rxd_can_d = can_active ? can_rx_s : !pull_low;
        rxd_lin_d = lin_mode_normal[0] ? lin_rx_s : !pull_low;
        hiz_d = !batt_s;
        lin_oe_n_d = ~(lin_drv_en & {2{batt_s}});
        l2_d = fail_source_bit;
        l2_oe_n_d = !(lin_fail_safe && batt_s);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rxd_can_q <= 1'b1;
            rxd_lin_q <= 1'b1;
            hiz_q <= 1'b1;
            lin_oe_n_q <= 2'h3;
            l2_q <= 1'b0;
            l2_oe_n_q <= 1'b1;
        end else begin
            rxd_can_q <= rxd_can_d;
            rxd_lin_q <= rxd_lin_d;
            hiz_q <= hiz_d;
            lin_oe_n_q <= lin_oe_n_d;
            l2_q <= l2_d;
            l2_oe_n_q <= l2_oe_n_d;
        end
    end

    assign rxd_can_o = rxd_can_q;
    assign rxd_lin_o = rxd_lin_q;
    assign rxd_can_oe_n = hiz_q;
    assign rxd_lin_oe_n = hiz_q;
    assign can_bus_oe_n = hiz_q;
    assign lin_bus_oe_n = lin_oe_n_q;
    assign lin_tx_enable = lin_drv_en;
    assign second_lin_transmit_out = l2_q;
    assign second_lin_transmit_oe_n = l2_oe_n_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    // Named masks keep the history checks on plain signals.
    logic [F_N-1:0] keep_v;
    logic [F_N-1:0] clr_v;

    assign keep_v = flags_q & ~flag_clear;
    assign clr_v = flag_clear & ~set_v;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_STICKY: assert property (
        keep_v != '0 |=> (flags_q & $past(keep_v)) == $past(keep_v))
        else $error("flag dropped without clear");

    AST_CLEAR: assert property (
        (clr_v & flags_q) != '0 |=> (flags_q & $past(clr_v)) == '0)
        else $error("flag not cleared by written one");
    AST_POWER_ON: assert property ($fell(rst) |-> ##[1:2] event_flags[F_POWER_ON])
        else $error("power-on flag missing");
    AST_HIZ: assert property (!batt_s |=> rxd_can_oe_n && can_bus_oe_n && lin_bus_oe_n == 2'h3)
        else $error("pins driven without battery");
    AST_WAKE: assert property (sleep && set_v != '0 |=> wake_request)
        else $error("no wake request for sleep event");
    AST_TSD: assert property (a[A_CAN_TSD] |=> event_flags[11])
        else $error("shutdown flag not captured");
    AST_SPI: assert property (
        spi_bad && !sleep && en_q[F_SPI_FAIL] |=> event_flags[F_SPI_FAIL])
        else $error("serial failure not captured");
    AST_RXD_IDLE: assert property (
        !can_active && !alert |=> rxd_can_o)
        else $error("receive pin low with no alert");

    AST_ALERT_LOW: assert property (
        !can_active && alert && batt_s && logic_s |=> !rxd_can_o)
        else $error("no low alert on receive pin");

    AST_RXD_LIN: assert property (
        lin_mode_normal[0] |=> rxd_lin_o == $past(lin_rx_s))
        else $error("bus stream missing on receive pin");

    AST_ENABLES_OFF: assert property ($fell(rst) |-> en_q == EN_ALWAYS)
        else $error("optional capture enabled at reset");

    AST_WARN_GATE: assert property (
        !dev_normal && flags_q[7:6] == 2'h0 |=> flags_q[7:6] == 2'h0)
        else $error("warning captured outside normal");

    AST_SLEEP_GATE: assert property (
        sleep && flags_q[19:18] == 2'h0 |=> flags_q[19:18] == 2'h0)
        else $error("bus failure captured in sleep");

    AST_FAILSAFE_PIN: assert property (
        lin_fail_safe && batt_s
        |=> !second_lin_transmit_oe_n && second_lin_transmit_out == $past(fail_source_bit))
        else $error("fail-safe source not shown");

    AST_CH2_QUIET: assert property (lin_fail_safe |=> !lin_tx_enable[1])
        else $error("second driver on in fail-safe");

    AST_FD_OVF: assert property (fd_err_overflow |=> event_flags[F_FD_OVF])
        else $error("frame detect overflow lost");
    COV_WAKE: cover property (wake_request);
    COV_CLEAR_SET: cover property ((flag_clear & set_v) != '0);
    COV_FAILSAFE: cover property (!second_lin_transmit_oe_n);
endmodule

/* testbench/host_model.sv */
module host_model (
    input wire logic clk,
    input wire logic [1:0] hold_low,
    output logic [1:0] txd
);
    timeunit 1ns;
    timeprecision 1ps;
    // The host only releases a transmit line after an edge and keeps it high until told otherwise.
    initial txd = 2'h3;
    always @(posedge clk) txd <= #1 ~hold_low;
endmodule

/* testbench/wake_event_capture_tb_top.sv */
module wake_event_capture_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sbc_event_pkg::*;
    localparam int DOM = 20;
    typedef struct {int what; logic [F_N-1:0] exp;} note_t;
    logic clk, rst, battery_supply_ok, logic_supply_ok, can_rx_bit, lin_rx_bit, lin_fail_safe, fail_source_bit;
    logic main_ldo_on, sensor_ldo_on, spi_cmd_done, spi_mode_illegal, spi_locked_write, fd_err_overflow;
    logic enable_write, second_lin_transmit_out, second_lin_transmit_oe_n, rxd_can_o, rxd_can_oe_n;
    logic rxd_lin_o, rxd_lin_oe_n, can_bus_oe_n, wake_request;
    logic [A_N-1:0] analog_evt;
    logic [1:0] lin_transmit_input, can_mode_field, lin_mode_normal, hold_low, lin_tx_enable, lin_bus_oe_n;
    logic [2:0] device_mode_field;
    logic [5:0] spi_clk_count;
    logic [F_N-1:0] enable_wdata, flag_clear, event_flags, capture_enable;
    int n_fail, check_count, seed;
    note_t notes[$];
    event sample;
    string nm[7] = '{"event_flags", "capture_enable", "lin_tx_enable", "rxd_pins", "wake_request", "lin2_pin", "oe_n"};

    host_model host (.clk, .hold_low, .txd(lin_transmit_input));
    wake_event_capture #(.LIN_DOM_CYC(DOM)) dut (.clk, .rst, .analog_evt, .battery_supply_ok, .logic_supply_ok,
        .can_rx_bit, .lin_rx_bit, .lin_transmit_input, .second_lin_transmit_out, .second_lin_transmit_oe_n,
        .device_mode_field, .can_mode_field, .lin_mode_normal, .lin_fail_safe, .fail_source_bit, .main_ldo_on,
        .sensor_ldo_on, .spi_cmd_done, .spi_clk_count, .spi_mode_illegal, .spi_locked_write, .fd_err_overflow,
        .enable_write, .enable_wdata, .flag_clear, .event_flags, .capture_enable, .lin_tx_enable, .rxd_can_o,
        .rxd_can_oe_n, .rxd_lin_o, .rxd_lin_oe_n, .can_bus_oe_n, .lin_bus_oe_n, .wake_request);

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [F_N-1:0] pick(input int w);
        case (w)
            0: return event_flags;
            1: return capture_enable;
            2: return F_N'(lin_tx_enable);
            3: return F_N'({rxd_can_o, rxd_lin_o});
            4: return F_N'(wake_request);
            5: return F_N'({second_lin_transmit_oe_n, second_lin_transmit_out});
            default: return F_N'({can_bus_oe_n, lin_bus_oe_n, rxd_can_oe_n, rxd_lin_oe_n});
        endcase
    endfunction

    function automatic int fmap(input int a);
        if (a < A_LIN_TW) return a;
        if (a < A_BUS_SIL) return a + 1;
        if (a == A_BUS_SIL) return 16;
        if (a < A_BUS_DOM) return F_TRX_FAIL;
        return a + 2;
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic note_exp(input int what, input logic [F_N-1:0] exp);
        notes.push_back('{what, exp});
        ->sample;
    endtask

    task automatic wr_en(input logic [F_N-1:0] v);
        enable_write = 1'b1;
        enable_wdata = v;
        cyc(1);
        enable_write = 1'b0;
    endtask

    task automatic clear_all;
        flag_clear = '1;
        cyc(1);
        flag_clear = '0;
        cyc(1);
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // The monitor drains every note queued in the time step of the trigger.
    initial begin
        forever begin
            @(sample);
            while (notes.size() > 0) begin
                note_t n;
                logic [F_N-1:0] seen;
                n = notes.pop_front();
                seen = pick(n.what);
                check_count++;
                if (seen !== n.exp) begin
                    n_fail++;
                    $display("wrong value %s expected %h seen %h", nm[n.what], n.exp, seen);
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [F_N-1:0] en;
        logic [F_N-1:0] exp;
        logic [5:0] lens [6];
        lens = '{SPI_LEN_A, SPI_LEN_B, SPI_LEN_C, 6'h1F, SPI_LEN_A, SPI_LEN_B};
        seed = 32'hC7202553;
        n_fail = 0;
        check_count = 0;
        rst = 1'b1;
        analog_evt = '0;
        battery_supply_ok = 1'b1;
        logic_supply_ok = 1'b1;
        can_rx_bit = 1'b1;
        lin_rx_bit = 1'b1;
        hold_low = 2'h0;
        lin_fail_safe = 1'b0;
        fail_source_bit = 1'b0;
        main_ldo_on = 1'b1;
        sensor_ldo_on = 1'b1;
        spi_cmd_done = 1'b0;
        spi_clk_count = SPI_LEN_A;
        spi_mode_illegal = 1'b0;
        spi_locked_write = 1'b0;
        fd_err_overflow = 1'b0;
        enable_write = 1'b0;
        enable_wdata = '0;
        flag_clear = '0;
        device_mode_field = DEV_NORMAL;
        // Silent keeps the undervoltage cause of the transceiver failure flag out of the event sweep.
        can_mode_field = CAN_SILENT;
        lin_mode_normal = 2'h3;
        cyc(20);
        rst = 1'b0;
        cyc(4);
        note_exp(1, EN_ALWAYS);
        note_exp(0, F_N'(1) << F_POWER_ON);
        flag_clear = ~(F_N'(1) << F_POWER_ON);
        cyc(1);
        flag_clear = '0;
        cyc(1);
        note_exp(0, F_N'(1) << F_POWER_ON);
        clear_all();
        for (int a = 0; a < A_N; a++) begin
            en = F_N'($random(seed));
            wr_en(en);
            en = en | EN_ALWAYS;
            note_exp(1, en);
            analog_evt[a] = 1'b1;
            cyc(2);
            analog_evt[a] = 1'b0;
            cyc(4);
            exp = '0;
            exp[fmap(a)] = en[fmap(a)];
            note_exp(0, exp);
            clear_all();
        end
        wr_en('0);
        fd_err_overflow = 1'b1;
        cyc(1);
        fd_err_overflow = 1'b0;
        cyc(1);
        note_exp(0, F_N'(1) << F_FD_OVF);
        clear_all();
        wr_en(F_N'(1) << F_SPI_FAIL);
        for (int i = 0; i < 7; i++) begin
            if (i == 6) device_mode_field = DEV_SLEEP;
            spi_clk_count = (i == 6) ? 6'h11 : lens[i];
            spi_mode_illegal = (i == 4);
            spi_locked_write = (i == 5);
            spi_cmd_done = 1'b1;
            cyc(1);
            spi_cmd_done = 1'b0;
            cyc(1);
            note_exp(0, (i > 2 && i < 6) ? F_N'(1) << F_SPI_FAIL : F_N'(0));
            clear_all();
        end
        wr_en(F_N'(1) << F_SPI_FAIL | F_N'(1));
        analog_evt[A_CAN_WAKE] = 1'b1;
        for (int k = 0; k < 8 && event_flags[0] !== 1'b1; k++) cyc(1);
        if (event_flags[0] !== 1'b1) begin
            n_fail++;
            $display("wrong value event_flags expected 1 seen 0");
            complete_run();
        end
        note_exp(4, F_N'(1));
        analog_evt = '0;
        // The synchroniser still holds the event for two edges, each one a capture.
        cyc(3);
        note_exp(4, '0);
        device_mode_field = DEV_NORMAL;
        can_mode_field = 2'h0;
        lin_mode_normal = 2'h0;
        // The re-alert delay started by the serial checks must run out first.
        cyc(2000);
        note_exp(3, '0);
        wr_en('1);
        fd_err_overflow = 1'b1;
        cyc(1);
        fd_err_overflow = 1'b0;
        flag_clear = F_N'(1);
        cyc(1);
        flag_clear = '0;
        cyc(1);
        note_exp(3, F_N'(3));
        cyc(1980);
        note_exp(3, F_N'(3));
        cyc(40);
        note_exp(3, '0);
        can_mode_field = CAN_NORMAL;
        lin_mode_normal = 2'h1;
        can_rx_bit = 1'b0;
        lin_rx_bit = 1'b0;
        cyc(4);
        note_exp(3, '0);
        can_rx_bit = 1'b1;
        lin_rx_bit = 1'b1;
        cyc(4);
        note_exp(3, F_N'(3));
        lin_mode_normal = 2'h0;
        // The first input is low before Normal entry, so the entry guard blocks it.
        hold_low = 2'h1;
        cyc(4);
        note_exp(2, '0);
        lin_mode_normal = 2'h3;
        cyc(1100);
        note_exp(2, F_N'(2));
        hold_low = 2'h0;
        cyc(990);
        note_exp(2, F_N'(2));
        cyc(20);
        note_exp(2, F_N'(3));
        wr_en(F_N'(1) << F_LIN_TXD_TO);
        clear_all();
        hold_low = 2'h1;
        cyc(18);
        note_exp(2, F_N'(3));
        cyc(10);
        note_exp(2, F_N'(2));
        note_exp(0, F_N'(1) << F_LIN_TXD_TO);
        hold_low = 2'h0;
        cyc(990);
        note_exp(2, F_N'(2));
        cyc(20);
        note_exp(2, F_N'(3));
        lin_fail_safe = 1'b1;
        for (int i = 0; i < 4; i++) begin
            fail_source_bit = 1'($random(seed));
            cyc(2);
            note_exp(5, F_N'(fail_source_bit));
        end
        battery_supply_ok = 1'b0;
        cyc(4);
        note_exp(6, F_N'(5'h1F));
        note_exp(5, F_N'({1'b1, fail_source_bit}));
        cyc(1);
        complete_run();
    end
endmodule
